// File: rtl/dsf_defs.vh
// Constants for the deep single-clock-sampled FIFO block
`ifndef DSF_DEFS_VH
`define DSF_DEFS_VH

`define DSF_DATA_W 18
`define DSF_ADDR_W 16
`define DSF_CNT_W 17
`define DSF_DEPTH_32K 17'h08000
`define DSF_DEPTH_64K 17'h10000
`define DSF_MEM_WORDS 65536
`define DSF_PTR_ONE 16'h0001
`define DSF_CNT_ONE 17'h00001
`define DSF_CNT_ZERO 17'h00000
`define DSF_AE_OFFSET_RST 18'h00007
`define DSF_AF_OFFSET_RST 18'h00007
`define DSF_CHAIN_PULSE 2'h3
`define DSF_PIN_W 29
// Positions of the sampled pins within the pin vector
`define DSF_P_WCLK 0
`define DSF_P_RCLK 1
`define DSF_P_WEN 2
`define DSF_P_REN 3
`define DSF_P_LD 4
`define DSF_P_OE 5
`define DSF_P_FLAG_SYNC_SELECT 6
`define DSF_P_FIRST 7
`define DSF_P_WXI 8
`define DSF_P_RXI 9
`define DSF_P_EXP 10
`define DSF_P_DLO 11
`define DSF_P_DHI 28

`endif

// File: rtl/dsf_fifo.v
// Deep 18-bit FIFO with pin-sampled write and read clocks, flags and depth cascade
`timescale 1ns/100ps
`include "dsf_defs.vh"

module dsf_fifo #(
    parameter DENSITY_64K = 0
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Write port pins
    input wire wr_clk_i,
    input wire wr_en_n_i,
    input wire [`DSF_DATA_W-1:0] data_i,
    // Read port pins
    input wire rd_clk_i,
    input wire rd_en_n_i,
    input wire out_en_n_i,
    output wire [`DSF_DATA_W-1:0] data_o,
    output wire data_oe_o,
    // Mode and offset pins
    input wire offset_load_n_i,
    input wire flag_sync_select_i,
    input wire depth_expand_i,
    // Cascade pins
    input wire first_in_chain_i,
    input wire wr_chain_in_n_i,
    input wire rd_chain_in_n_i,
    output wire rd_chain_out_n_o,
    // Status flags, active low
    output wire empty_flag_n_o,
    output wire almost_empty_flag_n_o,
    output wire half_full_flag_n_o,
    output wire almost_full_flag_n_o,
    output wire full_flag_n_o
);

    // Depth follows the density variant; half of it sets the half-full threshold
    localparam [`DSF_CNT_W-1:0] DEPTH = DENSITY_64K ? `DSF_DEPTH_64K : `DSF_DEPTH_32K;
    localparam [`DSF_CNT_W-1:0] HALF = DEPTH >> 1;

    // Pin sampler stages
    wire [`DSF_PIN_W-1:0] pins;
    reg [`DSF_PIN_W-1:0] pin_s1;
    reg [`DSF_PIN_W-1:0] pin_s2;
    reg [`DSF_PIN_W-1:0] pin_s3;
    reg [`DSF_PIN_W-1:0] pin_ag;
    wire [`DSF_PIN_W-1:0] next_ag;

    // Storage, pointers and occupancy
    reg [`DSF_DATA_W-1:0] mem [0:`DSF_MEM_WORDS-1];
    reg [`DSF_ADDR_W-1:0] wr_ptr;
    reg [`DSF_ADDR_W-1:0] rd_ptr;
    reg [`DSF_CNT_W-1:0] count;

    // Offset register words and their sequence pointers
    reg [`DSF_DATA_W-1:0] ae_offset;
    reg [`DSF_DATA_W-1:0] af_offset;
    reg ld_wr_sel;
    reg ld_rd_sel;

    // Registered outputs
    reg [`DSF_DATA_W-1:0] dout;
    reg empty_n;
    reg full_n;
    reg ae_sync_n;
    reg af_sync_n;
    reg ae_async_n;
    reg af_async_n;
    reg half_n;

    // Cascade state
    reg expand;
    reg wr_token;
    reg rd_token;
    reg [1:0] wxo_cnt;
    reg [1:0] rxo_cnt;

    // Pin vector, packed in the bit order named in the constants header
    assign pins = {
        data_i,
        depth_expand_i,
        rd_chain_in_n_i,
        wr_chain_in_n_i,
        first_in_chain_i,
        flag_sync_select_i,
        out_en_n_i,
        offset_load_n_i,
        rd_en_n_i,
        wr_en_n_i,
        rd_clk_i,
        wr_clk_i
    };

    // Three-stage sampling; a bit's value is accepted once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < `DSF_PIN_W; g = g + 1) begin : g_agree
            assign next_ag[g] = (pin_s2[g] == pin_s3[g]) ? pin_s3[g] : pin_ag[g];
        end
    endgenerate

    // No reset: stages settle from the pins within four clocks
    always @(posedge clk_i) begin
        pin_s1 <= pins;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
        pin_ag <= next_ag;
    end

    function rose;
        input [`DSF_PIN_W-1:0] nxt;
        input [`DSF_PIN_W-1:0] cur;
        input integer bit_idx;
        begin
            rose = nxt[bit_idx] & ~cur[bit_idx];
        end
    endfunction

    function fell;
        input [`DSF_PIN_W-1:0] nxt;
        input [`DSF_PIN_W-1:0] cur;
        input integer bit_idx;
        begin
            fell = ~nxt[bit_idx] & cur[bit_idx];
        end
    endfunction

    // Pointer advance, wrapping at the chosen density rather than the array size
    function [`DSF_ADDR_W-1:0] ptr_next;
        input [`DSF_ADDR_W-1:0] ptr;
        begin
            if (ptr == DEPTH[`DSF_ADDR_W-1:0] - `DSF_PTR_ONE) begin
                ptr_next = {`DSF_ADDR_W{1'b0}};
            end else begin
                ptr_next = ptr + `DSF_PTR_ONE;
            end
        end
    endfunction

    // Each pin clock is an event here, so tied or independent clocks both work
    wire wr_edge = rose(next_ag, pin_ag, `DSF_P_WCLK);
    wire rd_edge = rose(next_ag, pin_ag, `DSF_P_RCLK);
    wire [`DSF_DATA_W-1:0] din = pin_ag[`DSF_P_DHI:`DSF_P_DLO];
    wire wen = ~pin_ag[`DSF_P_WEN];
    wire ren = ~pin_ag[`DSF_P_REN];
    wire ld = ~pin_ag[`DSF_P_LD];
    wire flag_sync_select_async = pin_ag[`DSF_P_FLAG_SYNC_SELECT];

    // Token grants arrive as falling edges on the chain inputs
    wire wxi_fell = fell(next_ag, pin_ag, `DSF_P_WXI);
    wire rxi_fell = fell(next_ag, pin_ag, `DSF_P_RXI);

    // Gated by the registered flags, which only ever lag toward safety
    wire do_wr = wr_edge & wen & ~ld & full_n & wr_token;
    wire do_rd = rd_edge & ren & ~ld & empty_n & rd_token;
    wire do_ld_wr = wr_edge & wen & ld;
    wire do_ld_rd = rd_edge & ren & ld;

    // Occupancy after this clock's accepted write and read
    wire [`DSF_CNT_W-1:0] cnt_inc = do_wr ? `DSF_CNT_ONE : `DSF_CNT_ZERO;
    wire [`DSF_CNT_W-1:0] cnt_dec = do_rd ? `DSF_CNT_ONE : `DSF_CNT_ZERO;
    wire [`DSF_CNT_W-1:0] next_count = count + cnt_inc - cnt_dec;
    wire ae_now_n = ~(next_count <= {1'b0, ae_offset[`DSF_CNT_W-2:0]});
    wire af_now_n = ~(next_count >= DEPTH - {1'b0, af_offset[`DSF_CNT_W-2:0]});

    // Storage has no reset; only accepted writes touch it
    always @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= din;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= {`DSF_ADDR_W{1'b0}};
            rd_ptr <= {`DSF_ADDR_W{1'b0}};
            count <= `DSF_CNT_ZERO;
            dout <= {`DSF_DATA_W{1'b0}};
            ae_offset <= `DSF_AE_OFFSET_RST;
            af_offset <= `DSF_AF_OFFSET_RST;
            ld_wr_sel <= 1'b0;
            ld_rd_sel <= 1'b0;
        end else begin
            count <= next_count;
            if (do_wr) begin
                wr_ptr <= ptr_next(wr_ptr);
            end
            if (do_rd) begin
                rd_ptr <= ptr_next(rd_ptr);
                dout <= mem[rd_ptr];
            end
            // Offset register is two words, empty side first, then full side
            if (do_ld_wr) begin
                if (ld_wr_sel) begin
                    af_offset <= din;
                end else begin
                    ae_offset <= din;
                end
                ld_wr_sel <= ~ld_wr_sel;
            end
            if (do_ld_rd) begin
                dout <= ld_rd_sel ? af_offset : ae_offset;
                ld_rd_sel <= ~ld_rd_sel;
            end
        end
    end

    // Flags
    // Empty and full move only on their own pin-clock events, so a write into
    // an empty buffer shows only at the next read clock; that read event cannot
    // yet fetch the word, trading one read clock for glitch-free flags
    always @(posedge clk_i) begin
        if (rst_i) begin
            empty_n <= 1'b0;
            full_n <= 1'b1;
            ae_sync_n <= 1'b0;
            af_sync_n <= 1'b1;
            ae_async_n <= 1'b0;
            af_async_n <= 1'b1;
            half_n <= 1'b1;
        end else begin
            // Synchronous almost flags move only with their own pin clocks
            if (rd_edge) begin
                empty_n <= (next_count != `DSF_CNT_ZERO);
                ae_sync_n <= ae_now_n;
            end
            if (wr_edge) begin
                full_n <= (next_count != DEPTH);
                af_sync_n <= af_now_n;
            end
            // Asynchronous mode: recomputed on every system clock
            ae_async_n <= ae_now_n;
            af_async_n <= af_now_n;
            // Exactly half the depth still reads as not half full
            half_n <= ~(next_count > HALF);
        end
    end

    // Depth expansion: tokens grant write and read access around the ring
    always @(posedge clk_i) begin
        if (rst_i) begin
            // Straps are captured while reset is held
            expand <= pin_ag[`DSF_P_EXP];
            wr_token <= ~pin_ag[`DSF_P_EXP] | ~pin_ag[`DSF_P_FIRST];
            rd_token <= ~pin_ag[`DSF_P_EXP] | ~pin_ag[`DSF_P_FIRST];
            wxo_cnt <= 2'h0;
            rxo_cnt <= 2'h0;
        end else begin
            // Pulse held several cycles so the next device's sampler can agree on it
            if (wxo_cnt != 2'h0) begin
                wxo_cnt <= wxo_cnt - 2'h1;
            end
            if (rxo_cnt != 2'h0) begin
                rxo_cnt <= rxo_cnt - 2'h1;
            end
            // Filling passes the write token on, emptying passes the read token
            if (expand) begin
                if (do_wr && next_count == DEPTH) begin
                    wr_token <= 1'b0;
                    wxo_cnt <= `DSF_CHAIN_PULSE;
                end else if (wxi_fell) begin
                    wr_token <= 1'b1;
                end
                if (do_rd && next_count == `DSF_CNT_ZERO) begin
                    rd_token <= 1'b0;
                    rxo_cnt <= `DSF_CHAIN_PULSE;
                end else if (rxi_fell) begin
                    rd_token <= 1'b1;
                end
            end
        end
    end

    // Read data, empty and full leave straight from their registers; half full carries the write chain pulse when cascaded
    assign data_o = dout;
    // The bus driver itself sits outside; this only tells it when to drive
    assign data_oe_o = ~pin_ag[`DSF_P_OE];
    assign empty_flag_n_o = empty_n;
    assign full_flag_n_o = full_n;
    assign almost_empty_flag_n_o = flag_sync_select_async ? ae_async_n : ae_sync_n;
    assign almost_full_flag_n_o = flag_sync_select_async ? af_async_n : af_sync_n;
    assign half_full_flag_n_o = expand ? (wxo_cnt == 2'h0) : half_n;
    assign rd_chain_out_n_o = (rxo_cnt == 2'h0);

endmodule // dsf_fifo

// File: verification/dsf_fifo_properties.sv
// Pin-level assertions for the deep FIFO
`timescale 1ns/100ps
`include "dsf_defs.vh"
module dsf_fifo_checker (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Observed pins
    input wire wr_clk_i,
    input wire rd_clk_i,
    input wire out_en_n_i,
    input wire depth_expand_i,
    input wire [`DSF_DATA_W-1:0] data_o,
    input wire data_oe_o,
    input wire rd_chain_out_n_o,
    input wire empty_flag_n_o,
    input wire almost_empty_flag_n_o,
    input wire half_full_flag_n_o,
    input wire almost_full_flag_n_o,
    input wire full_flag_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Pin clocks pass a three-stage sampler, so look a few cycles back
    sequence s_rd;
        $past(rd_clk_i,2) | $past(rd_clk_i,3) | $past(rd_clk_i,4) | $past(rd_clk_i,5);
    endsequence
    sequence s_wr;
        $past(wr_clk_i,2) | $past(wr_clk_i,3) | $past(wr_clk_i,4) | $past(wr_clk_i,5);
    endsequence
    sequence s_oe_on;
        (!out_en_n_i) [*6];
    endsequence
    a_empty_rd_edge: assert property ($changed(empty_flag_n_o) |-> s_rd)
        else $error("empty flag moved without a read clock");
    a_full_wr_edge: assert property ($changed(full_flag_n_o) |-> s_wr)
        else $error("full flag moved without a write clock");
    a_data_rd_edge: assert property ($changed(data_o) |-> s_rd)
        else $error("read data moved without a read clock");
    a_oe_drive: assert property (s_oe_on |-> data_oe_o)
        else $error("outputs not driven with enable low");
    a_oe_float: assert property (out_en_n_i [*6] |-> !data_oe_o)
        else $error("outputs driven with enable high");
    a_full_almost_full: assert property (!full_flag_n_o |-> !almost_full_flag_n_o)
        else $error("full without almost full");
    a_chain_quiet: assert property ((!depth_expand_i) [*8] |-> rd_chain_out_n_o)
        else $error("read chain pulse outside cascade");
    a_reset_state: assert property (disable iff (1'b0) rst_i [*2] |->
        !empty_flag_n_o && full_flag_n_o && half_full_flag_n_o && almost_full_flag_n_o
        && !almost_empty_flag_n_o && data_o == 18'h00000)
        else $error("state after reset is wrong");
endmodule // dsf_fifo_checker

// File: verification/dsf_peer.sv
// Producer and consumer pin model for the FIFO ports
`timescale 1ns/100ps
module dsf_peer (
    // Clock
    input wire clk_i,
    // Write side pins
    output reg wr_clk_o,
    output reg wr_en_n_o,
    output reg [17:0] data_o,
    // Read side pins
    output reg rd_clk_o,
    output reg rd_en_n_o,
    output reg offset_load_n_o
);
    // Idle levels while reset is applied
    initial begin
        wr_clk_o = 1'b0;
        rd_clk_o = 1'b0;
        wr_en_n_o = 1'b1;
        rd_en_n_o = 1'b1;
        offset_load_n_o = 1'b1;
        data_o = 18'h00000;
    end
    // Phases of four clocks give the sampler two agreeing samples
    task pin_cycle(input wr, input en, input ld, input [17:0] d);
        begin
            @(posedge clk_i);
            offset_load_n_o <= !ld;
            if (wr) begin
                wr_en_n_o <= !en;
                data_o <= d;
            end else begin
                rd_en_n_o <= !en;
            end
            @(posedge clk_i);
            if (wr)
                wr_clk_o <= 1'b1;
            else
                rd_clk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            wr_clk_o <= 1'b0;
            rd_clk_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            wr_en_n_o <= 1'b1;
            rd_en_n_o <= 1'b1;
            offset_load_n_o <= 1'b1;
            // Released data must not look like the last word
            data_o <= ~d;
        end
    endtask
endmodule // dsf_peer

// File: verification/testbench.sv
// Self-checking bench for the deep FIFO
`timescale 1ns/100ps
`include "dsf_defs.vh"
module testbench;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg oe_n = 1'b0;
    reg sync_sel = 1'b1;
    wire wr_clk, wr_en_n, rd_clk, rd_en_n, ld_n, oe, e_n, ae_n, hf_n, af_n, f_n, rxo_n;
    wire [`DSF_DATA_W-1:0] din, dout;
    integer err_total = 0;
    integer total_checks = 0;
    always #50 clk_i = ~clk_i;
    dsf_peer u_dsf_peer (.clk_i(clk_i), .wr_clk_o(wr_clk), .wr_en_n_o(wr_en_n), .data_o(din),
        .rd_clk_o(rd_clk), .rd_en_n_o(rd_en_n), .offset_load_n_o(ld_n));
    dsf_fifo #(.DENSITY_64K(0)) u_dsf_fifo (.clk_i(clk_i), .rst_i(rst_i), .wr_clk_i(wr_clk),
        .wr_en_n_i(wr_en_n), .data_i(din), .rd_clk_i(rd_clk), .rd_en_n_i(rd_en_n),
        .out_en_n_i(oe_n), .data_o(dout), .data_oe_o(oe), .offset_load_n_i(ld_n),
        .flag_sync_select_i(sync_sel), .depth_expand_i(1'b0), .first_in_chain_i(1'b0),
        .wr_chain_in_n_i(1'b0), .rd_chain_in_n_i(1'b0), .rd_chain_out_n_o(rxo_n),
        .empty_flag_n_o(e_n), .almost_empty_flag_n_o(ae_n), .half_full_flag_n_o(hf_n),
        .almost_full_flag_n_o(af_n), .full_flag_n_o(f_n));
    task check(input [17:0] seen, input [17:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("Error at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task rd(input ld, input [17:0] exp);
        begin
            u_dsf_peer.pin_cycle(1'b0, 1'b1, ld, 18'h00000);
            @(negedge clk_i);
            check(dout, exp);
        end
    endtask
    task wr(input ld, input [17:0] d);
        u_dsf_peer.pin_cycle(1'b1, 1'b1, ld, d);
    endtask
    task t_reset;
        begin
            @(negedge clk_i);
            check(e_n, 1'b0);
            check(f_n, 1'b1);
            check(ae_n, 1'b0);
            check(af_n, 1'b1);
            check(hf_n, 1'b1);
            check(dout, 18'h00000);
            check(rxo_n, 1'b1);
            check(oe, 1'b1);
            $display("t_reset done");
        end
    endtask
    task t_order;
        begin
            wr(1'b0, 18'h3ffff);
            wr(1'b0, 18'h00001);
            wr(1'b0, 18'h2a5a5);
            u_dsf_peer.pin_cycle(1'b0, 1'b0, 1'b0, 18'h00000);
            @(negedge clk_i);
            check(dout, 18'h00000);
            check(e_n, 1'b1);
            check(f_n, 1'b1);
            rd(1'b0, 18'h3ffff);
            rd(1'b0, 18'h00001);
            rd(1'b0, 18'h2a5a5);
            check(e_n, 1'b0);
            rd(1'b0, 18'h2a5a5);
            $display("t_order done");
        end
    endtask
    task t_offset;
        begin
            wr(1'b1, 18'h00002);
            wr(1'b1, 18'h00005);
            rd(1'b1, 18'h00002);
            rd(1'b1, 18'h00005);
            wr(1'b0, 18'h00011);
            wr(1'b0, 18'h00022);
            @(negedge clk_i);
            check(ae_n, 1'b0);
            wr(1'b0, 18'h00033);
            @(negedge clk_i);
            check(ae_n, 1'b1);
            @(posedge clk_i);
            sync_sel <= 1'b0;
            u_dsf_peer.pin_cycle(1'b0, 1'b0, 1'b0, 18'h00000);
            rd(1'b0, 18'h00011);
            check(ae_n, 1'b0);
            wr(1'b0, 18'h00044);
            @(negedge clk_i);
            check(ae_n, 1'b0);
            $display("t_offset done");
        end
    endtask
    task t_oe;
        begin
            @(posedge clk_i);
            oe_n <= 1'b1;
            repeat (8) @(negedge clk_i);
            check(oe, 1'b0);
            @(posedge clk_i);
            oe_n <= 1'b0;
            repeat (8) @(negedge clk_i);
            check(oe, 1'b1);
            $display("t_oe done");
        end
    endtask
    task t_rereset;
        begin
            @(posedge clk_i);
            rst_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            rst_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            u_dsf_peer.pin_cycle(1'b0, 1'b0, 1'b0, 18'h00000);
            @(negedge clk_i);
            check(e_n, 1'b0);
            check(ae_n, 1'b0);
            check(dout, 18'h00000);
            rd(1'b0, 18'h00000);
            $display("t_rereset done");
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_reset;
        t_order;
        t_offset;
        t_oe;
        t_rereset;
        results;
    end
    // All tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total = err_total + 1;
        $display("Error at %0t: watchdog expired", $time);
        results;
    end
endmodule // testbench
bind dsf_fifo dsf_fifo_checker u_dsf_fifo_checker (.clk_i(clk_i), .rst_i(rst_i),
    .wr_clk_i(wr_clk_i), .rd_clk_i(rd_clk_i), .out_en_n_i(out_en_n_i),
    .depth_expand_i(depth_expand_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .rd_chain_out_n_o(rd_chain_out_n_o), .empty_flag_n_o(empty_flag_n_o),
    .almost_empty_flag_n_o(almost_empty_flag_n_o), .half_full_flag_n_o(half_full_flag_n_o),
    .almost_full_flag_n_o(almost_full_flag_n_o), .full_flag_n_o(full_flag_n_o));
